// >>> inc/tcp_pkg.sv
// shared constants for the touch controller i2c target port
package tcp_pkg;
  localparam int         CLK_MHZ        = 100;
  // ****************************************
  // bus addresses and register map
  // ****************************************
  localparam logic [6:0] DEV_ADR_DEF    = 7'h44;
  localparam logic [6:0] DEV_ADR_ALT    = 7'h45;
  localparam logic [7:0] REG_TMO        = 8'h85;
  localparam logic [7:0] REG_SET        = 8'hf2;
  localparam int         SET_STOP_IGN   = 0;
  localparam int         SET_BUS_RST    = 1;
  localparam int         SET_END_WIN    = 7;
  localparam logic [15:0] SET_RST       = 16'h0000;
  // ****************************************
  // timing
  // ****************************************
  localparam int         TMO_DEF_US     = 10240;
  localparam int         TMO_UNIT_US    = 640;
  localparam int         TMO_UNIT_CYC   = TMO_UNIT_US * CLK_MHZ;
  localparam logic [15:0] TMO_RST       = 16'(TMO_DEF_US / TMO_UNIT_US);
  localparam int         ABANDON_TYP_US = 250;
  localparam int         ABANDON_MAX_US = 300;
  localparam int         ABANDON_CYC    = ABANDON_TYP_US * CLK_MHZ;
  localparam int         ABANDON_MAX_CYC = ABANDON_MAX_US * CLK_MHZ;
  localparam int         LOAD_CYC       = 4;
  localparam int         WDT_IDLE_US    = 2000;
  localparam int         WDT_IDLE_CYC   = WDT_IDLE_US * CLK_MHZ;
  localparam int         POR_WIN_US     = 1000;
  localparam int         POR_WIN_CYC    = POR_WIN_US * CLK_MHZ;
  localparam int         BUS_LOW_US     = 100;
  localparam int         BUS_LOW_CYC    = BUS_LOW_US * CLK_MHZ;
  // ****************************************
  // protocol states
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_WAIT = 5'h10
  } tcp_st_e;
  typedef enum logic [2:0] {
    RK_ADR = 3'h1,
    RK_CMD = 3'h2,
    RK_DAT = 3'h4
  } tcp_rk_e;
endpackage : tcp_pkg

// >>> src/tcp_i2c_target.sv
// touch controller i2c target port: bit engine, window control, watchdog
`timescale 1ns/1ps
`default_nettype none
// Operation
// - always ack own address, little stretch
// - window shown by open-drain low line
// - two bytes per address-command, byte0 first
// - address 0x44 floating pin, 0x45 grounded
// - current-address read, master nacks last byte
// - writes carry address-command then acked data
// - stop-ignore bit keeps window open
// - end-window bit closes at next stop
// - settings apply whenever written before stop
// - timeout closes window, restarts per byte
// - timeout defaults to 10.24 ms
// - timeout close skips commands, keeps registers
// - early revision holds line through ignored stops
// - later revision releases line at each stop
// - watchdog on stall not multiple of nine
// - watchdog when addressed then bus silent
// - watchdog on bus low during power-on check, or reset command
// - stretch after address-command while loading data
// - stretch 250 us when addressed outside window
module tcp_i2c_target #(
  parameter bit LATE_REV     = 1'b1,
  parameter bit FIXED_ADR    = 1'b0,
  parameter int ABANDON_CYC  = tcp_pkg::ABANDON_CYC,
  parameter int TMO_UNIT_CYC = tcp_pkg::TMO_UNIT_CYC,
  parameter int WDT_IDLE_CYC = tcp_pkg::WDT_IDLE_CYC,
  parameter int POR_WIN_CYC  = tcp_pkg::POR_WIN_CYC,
  parameter int BUS_LOW_CYC  = tcp_pkg::BUS_LOW_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_clk,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  output logic             rdy_o,
  output logic             rdy_oe_n,
  input  wire logic        adr_sel,
  input  wire logic        win_req,
  output logic [7:0]       mem_addr,
  input  wire logic [15:0] mem_rdata,
  output logic [15:0]      mem_wdata,
  output logic             mem_we,
  output logic             cmd_exec,
  output logic             wdt_rst,
  output logic             win_open
);
  // ****************************************
  // link side: bits shifted on the master's clock
  // ****************************************
  logic [7:0] lsh_ff;
  logic       ltg_ff;
  // async clear: scl stands still outside frames, so a synced reset would eat bits
  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      lsh_ff <= 8'h00;
      ltg_ff <= 1'b0;
    end
    else
    begin
      lsh_ff <= {lsh_ff[6:0], sda_i};
      ltg_ff <= ~ltg_ff;
    end
  end
  // ****************************************
  // crossings into the system clock
  // ****************************************
  logic [2:0] scl_s_ff;
  logic [2:0] sda_s_ff;
  logic [2:0] tg_s_ff;
  logic [1:0] asel_s_ff;
  logic       lo_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_s_ff  <= 3'h7;
      sda_s_ff  <= 3'h7;
      tg_s_ff   <= 3'h0;
      asel_s_ff <= 2'h3;
    end
    else
    begin
      scl_s_ff  <= {scl_s_ff[1:0], scl_i};
      sda_s_ff  <= {sda_s_ff[1:0], sda_i};
      tg_s_ff   <= {tg_s_ff[1:0], ltg_ff};
      asel_s_ff <= {asel_s_ff[0], adr_sel};
    end
  end
  always_ff @(posedge clk)
  begin
    lo_ff <= 1'b0;
  end
  logic sta;
  logic sto;
  logic bev;
  logic fall;
  logic byev;
  logic act;
  assign sta  = scl_s_ff[1] & scl_s_ff[2] & sda_s_ff[2] & ~sda_s_ff[1];
  assign sto  = scl_s_ff[1] & scl_s_ff[2] & ~sda_s_ff[2] & sda_s_ff[1];
  assign bev  = tg_s_ff[1] ^ tg_s_ff[2];
  assign fall = scl_s_ff[2] & ~scl_s_ff[1];
  logic [3:0] bcnt_ff;
  assign byev = bev & (bcnt_ff == 4'd7);
  assign act  = sta | sto | bev | fall;
  logic [6:0] my_adr_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
      my_adr_ff <= tcp_pkg::DEV_ADR_DEF;
    else if (FIXED_ADR || asel_s_ff[1])
      my_adr_ff <= tcp_pkg::DEV_ADR_DEF;
    else
      my_adr_ff <= tcp_pkg::DEV_ADR_ALT;
  end
  // ****************************************
  // protocol engine
  // ****************************************
  tcp_pkg::tcp_st_e st_ff;
  tcp_pkg::tcp_rk_e rk_ff;
  logic        rw_ff;
  logic        bsel_ff;
  logic        inc_ff;
  logic        sda_oe_n_ff;
  logic        scl_oe_n_ff;
  logic [19:0] str_ff;
  logic [7:0]  mem_addr_ff;
  logic [7:0]  wbuf_ff;
  logic [15:0] mem_wdata_ff;
  logic        mem_we_ff;
  logic        adr_done_ff;
  logic        win_ff;
  logic        wdt_rst_ff;
  logic [15:0] tmo_ff;
  logic [15:0] set_ff;
  logic [15:0] rword;
  logic [7:0]  txb;
  always_comb
  begin
    rword = mem_rdata;
    if (mem_addr_ff == tcp_pkg::REG_TMO)
      rword = tmo_ff;
    else if (mem_addr_ff == tcp_pkg::REG_SET)
      rword = set_ff;
    txb = bsel_ff ? rword[15:8] : rword[7:0];
  end
  always_ff @(posedge clk)
  begin
    if (rst || wdt_rst_ff)
    begin
      st_ff        <= tcp_pkg::ST_IDLE;
      rk_ff        <= tcp_pkg::RK_ADR;
      bcnt_ff      <= 4'd0;
      rw_ff        <= 1'b0;
      bsel_ff      <= 1'b0;
      inc_ff       <= 1'b0;
      sda_oe_n_ff  <= 1'b1;
      scl_oe_n_ff  <= 1'b1;
      str_ff       <= 20'd0;
      mem_addr_ff  <= 8'h00;
      wbuf_ff      <= 8'h00;
      mem_wdata_ff <= 16'h0000;
      mem_we_ff    <= 1'b0;
      adr_done_ff  <= 1'b0;
    end
    else
    begin
      mem_we_ff   <= 1'b0;
      adr_done_ff <= 1'b0;
      if (str_ff != 20'd0)
        str_ff <= str_ff - 20'd1;
      if (str_ff == 20'd1)
        scl_oe_n_ff <= 1'b1;
      if (bev)
        bcnt_ff <= bcnt_ff + 4'd1;
      if (sta)
      begin
        st_ff       <= tcp_pkg::ST_RX;
        rk_ff       <= tcp_pkg::RK_ADR;
        bcnt_ff     <= 4'd0;
        sda_oe_n_ff <= 1'b1;
      end
      else if (sto)
      begin
        st_ff       <= tcp_pkg::ST_IDLE;
        sda_oe_n_ff <= 1'b1;
      end
      else
      begin
        unique case (st_ff)
          tcp_pkg::ST_RX:
            if (byev)
            begin
              st_ff <= tcp_pkg::ST_ACK;
              unique case (rk_ff)
                tcp_pkg::RK_ADR:
                  if (lsh_ff[7:1] == my_adr_ff)
                  begin
                    rw_ff <= lsh_ff[0];
                    if (lsh_ff[0])
                      bsel_ff <= 1'b0;
                  end
                  else
                    st_ff <= tcp_pkg::ST_WAIT;
                tcp_pkg::RK_CMD:
                begin
                  mem_addr_ff <= lsh_ff;
                  bsel_ff     <= 1'b0;
                end
                tcp_pkg::RK_DAT:
                  if (!bsel_ff)
                  begin
                    wbuf_ff <= lsh_ff;
                    bsel_ff <= 1'b1;
                  end
                  else
                  begin
                    mem_wdata_ff <= {lsh_ff, wbuf_ff};
                    mem_we_ff    <= 1'b1;
                    bsel_ff      <= 1'b0;
                    inc_ff       <= 1'b1;
                  end
              endcase
            end
          tcp_pkg::ST_ACK:
            if (fall && bcnt_ff == 4'd8)
            begin
              sda_oe_n_ff <= 1'b0;
              if (rk_ff == tcp_pkg::RK_ADR && !win_ff)
              begin
                str_ff      <= 20'(ABANDON_CYC);
                scl_oe_n_ff <= 1'b0;
              end
              else if (rk_ff == tcp_pkg::RK_CMD)
              begin
                str_ff      <= 20'(tcp_pkg::LOAD_CYC);
                scl_oe_n_ff <= 1'b0;
              end
            end
            else if (fall && bcnt_ff == 4'd9)
            begin
              bcnt_ff     <= 4'd0;
              adr_done_ff <= (rk_ff == tcp_pkg::RK_ADR);
              if (rk_ff == tcp_pkg::RK_ADR && rw_ff)
              begin
                st_ff       <= tcp_pkg::ST_TX;
                sda_oe_n_ff <= txb[7];
              end
              else
              begin
                st_ff       <= tcp_pkg::ST_RX;
                sda_oe_n_ff <= 1'b1;
                rk_ff       <= (rk_ff == tcp_pkg::RK_ADR) ? tcp_pkg::RK_CMD
                                                          : tcp_pkg::RK_DAT;
                if (inc_ff)
                begin
                  mem_addr_ff <= mem_addr_ff + 8'd1;
                  inc_ff      <= 1'b0;
                end
              end
            end
          tcp_pkg::ST_TX:
            if (fall && bcnt_ff < 4'd8)
              sda_oe_n_ff <= txb[~bcnt_ff[2:0]];
            else if (fall && bcnt_ff == 4'd8)
              sda_oe_n_ff <= 1'b1;
            else if (bev && bcnt_ff == 4'd8)
            begin
              if (lsh_ff[0])
                st_ff <= tcp_pkg::ST_WAIT;
              else if (bsel_ff)
              begin
                bsel_ff     <= 1'b0;
                mem_addr_ff <= mem_addr_ff + 8'd1;
              end
              else
                bsel_ff <= 1'b1;
            end
            else if (fall && bcnt_ff == 4'd9)
            begin
              bcnt_ff     <= 4'd0;
              sda_oe_n_ff <= txb[7];
            end
          tcp_pkg::ST_IDLE,
          tcp_pkg::ST_WAIT:
            sda_oe_n_ff <= 1'b1;
        endcase
      end
    end
  end
  // ****************************************
  // settings registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst || wdt_rst_ff)
    begin
      tmo_ff <= tcp_pkg::TMO_RST;
      set_ff <= tcp_pkg::SET_RST;
    end
    else if (mem_we_ff && mem_addr_ff == tcp_pkg::REG_TMO)
      tmo_ff <= mem_wdata_ff;
    else if (mem_we_ff && mem_addr_ff == tcp_pkg::REG_SET)
    begin
      set_ff <= mem_wdata_ff;
      set_ff[tcp_pkg::SET_BUS_RST] <= 1'b0;
    end
  end
  // ****************************************
  // communication window
  // ****************************************
  function automatic logic [25:0] tmo_load(input logic [7:0] u);
    tmo_load = 26'(u) * 26'(TMO_UNIT_CYC);
  endfunction : tmo_load
  logic [25:0] tmo_cnt_ff;
  logic        rdy_oe_n_ff;
  logic        wrote_ff;
  logic        cmd_exec_ff;
  logic        stop_close;
  // a set end-window bit overrides stop-ignore
  assign stop_close = !set_ff[tcp_pkg::SET_STOP_IGN] || set_ff[tcp_pkg::SET_END_WIN];
  always_ff @(posedge clk)
  begin
    if (rst || wdt_rst_ff)
    begin
      win_ff      <= 1'b0;
      rdy_oe_n_ff <= 1'b1;
      tmo_cnt_ff  <= 26'd0;
      wrote_ff    <= 1'b0;
      cmd_exec_ff <= 1'b0;
    end
    else
    begin
      cmd_exec_ff <= 1'b0;
      if (win_ff && tmo_cnt_ff != 26'd0)
        tmo_cnt_ff <= tmo_cnt_ff - 26'd1;
      if (byev)
        tmo_cnt_ff <= tmo_load(tmo_ff[7:0]);
      // a new period takes effect from the byte that carried it
      if (mem_we_ff && mem_addr_ff == tcp_pkg::REG_TMO)
        tmo_cnt_ff <= tmo_load(mem_wdata_ff[7:0]);
      if (mem_we_ff && win_ff)
        wrote_ff <= 1'b1;
      if (!win_ff && (win_req || adr_done_ff))
      begin
        win_ff      <= 1'b1;
        rdy_oe_n_ff <= 1'b0;
        tmo_cnt_ff  <= tmo_load(tmo_ff[7:0]);
      end
      else if (win_ff && sto && stop_close)
      begin
        win_ff      <= 1'b0;
        rdy_oe_n_ff <= 1'b1;
        cmd_exec_ff <= wrote_ff;
        wrote_ff    <= 1'b0;
      end
      else if (win_ff && tmo_cnt_ff == 26'd1 && !byev)
      begin
        win_ff      <= 1'b0;
        rdy_oe_n_ff <= 1'b1;
        wrote_ff    <= 1'b0;
      end
      else if (win_ff && sto && LATE_REV)
        rdy_oe_n_ff <= 1'b1;
      // early revision: line stays low through an ignored stop
    end
  end
  // ****************************************
  // watchdog
  // ****************************************
  logic [23:0] idle_ff;
  logic [3:0]  pcnt_ff;
  logic        hit_ff;
  logic [23:0] por_ff;
  logic [23:0] low_ff;
  logic        stall;
  logic        wdt_go;
  // idle time only counts while we are not the one holding scl
  assign stall  = idle_ff == 24'(WDT_IDLE_CYC - 1) && !act && str_ff == 20'd0;
  assign wdt_go = (stall && (pcnt_ff != 4'd0 || hit_ff))
                || low_ff == 24'(BUS_LOW_CYC - 1)
                || (mem_we_ff && mem_addr_ff == tcp_pkg::REG_SET
                    && mem_wdata_ff[tcp_pkg::SET_BUS_RST]);
  always_ff @(posedge clk)
  begin
    if (rst || wdt_rst_ff)
    begin
      idle_ff <= 24'd0;
      pcnt_ff <= 4'd0;
      hit_ff  <= 1'b0;
    end
    else
    begin
      if (act || str_ff != 20'd0)
        idle_ff <= 24'd0;
      else if (idle_ff != 24'(WDT_IDLE_CYC - 1))
        idle_ff <= idle_ff + 24'd1;
      if (sta || sto)
        pcnt_ff <= 4'd0;
      else if (bev)
        pcnt_ff <= (pcnt_ff == 4'd8) ? 4'd0 : pcnt_ff + 4'd1;
      if (adr_done_ff)
        hit_ff <= 1'b1;
      else if (sta || sto || bev)
        hit_ff <= 1'b0;
    end
  end
  // power-on bus check runs once after rst, not after a watchdog reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      por_ff <= 24'd0;
      low_ff <= 24'd0;
    end
    else
    begin
      if (por_ff != 24'(POR_WIN_CYC))
        por_ff <= por_ff + 24'd1;
      if (por_ff != 24'(POR_WIN_CYC) && !(scl_s_ff[1] && sda_s_ff[1]))
        low_ff <= low_ff + 24'd1;
      else
        low_ff <= 24'd0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      wdt_rst_ff <= 1'b0;
    else
      wdt_rst_ff <= wdt_go;
  end
  assign scl_o     = lo_ff;
  assign sda_o     = lo_ff;
  assign rdy_o     = lo_ff;
  assign scl_oe_n  = scl_oe_n_ff;
  assign sda_oe_n  = sda_oe_n_ff;
  assign rdy_oe_n  = rdy_oe_n_ff;
  assign mem_addr  = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_we    = mem_we_ff;
  assign cmd_exec  = cmd_exec_ff;
  assign wdt_rst   = wdt_rst_ff;
  assign win_open  = win_ff;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || wdt_rst_ff);
  a_addr_ack_low:
    assert property (st_ff == tcp_pkg::ST_ACK && fall && bcnt_ff == 4'd8
                     |=> !sda_oe_n_ff)
    else $error("ack not driven low");
  a_ack_in_stretch:
    assert property (!scl_oe_n_ff && st_ff == tcp_pkg::ST_ACK |-> !sda_oe_n_ff)
    else $error("ack dropped while stretching");
  a_rdy_closed:
    assert property (!win_ff |-> rdy_oe_n_ff)
    else $error("window line low with window closed");
  a_wr_pair:
    assert property (mem_we_ff |-> !bsel_ff && $past(bsel_ff))
    else $error("write strobe not after byte 1");
  a_stop_ignored:
    assert property (sto && win_ff && set_ff[0] && !set_ff[7]
                     && tmo_cnt_ff != 26'd1 |=> win_ff)
    else $error("ignored stop closed window");
  a_end_window:
    assert property (sto && win_ff && set_ff[7] |=> !win_ff)
    else $error("end-window stop did not close");
  a_tmo_close:
    assert property (win_ff && tmo_cnt_ff == 26'd1 && !byev && !sto
                     |=> !win_ff ##1 !cmd_exec_ff)
    else $error("timeout close wrong");
  a_cmd_on_stop:
    assert property (cmd_exec_ff |-> $past(sto) && !win_ff)
    else $error("commands run without stop");
  a_late_release:
    assert property (sto && win_ff && LATE_REV |=> rdy_oe_n_ff)
    else $error("line not released at stop");
  a_abandon_len:
    assert property (st_ff == tcp_pkg::ST_ACK && fall && bcnt_ff == 4'd8
                     && rk_ff == tcp_pkg::RK_ADR && !win_ff
                     |=> str_ff == 20'(ABANDON_CYC) && !scl_oe_n_ff)
    else $error("outside-window stretch wrong");
  a_stall_wdt:
    assert property (stall && pcnt_ff != 4'd0 |=> wdt_rst_ff)
    else $error("stalled transfer without watchdog");
endmodule : tcp_i2c_target
`default_nettype wire

// >>> verification/tcp_host_model.sv
// i2c host model: open-drain master with stretch-aware clocking
`timescale 1ns/1ps
`default_nettype none
module tcp_host_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low,
  output logic      hang
);
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hang    = 1'b0;
  end
  // ****
  // bit level
  // ****
  // scl stands still between frames; a stretch is waited out, but not forever
  task automatic rise();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl !== 1'b1 && n < 5000)
    begin
      #10;
      n++;
    end
    if (n == 5000)
      hang = 1'b1;
  endtask : rise
  // serves as start and as repeated start
  task automatic start();
    sda_low = 1'b0;
    #20;
    rise();
    #40;
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
    #20;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    #20;
    rise();
    #40;
    sda_low = 1'b0;
    #40;
  endtask : stop
  // 20 ns hold after the fall keeps sda edges clear of the target's scl view
  task automatic bitx(input logic b, output logic r);
    sda_low = ~b;
    #20;
    rise();
    r = sda;
    #40;
    scl_low = 1'b1;
    #20;
  endtask : bitx
  // ****
  // byte level
  // ****
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wr
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(last, r);
  endtask : rd
endmodule : tcp_host_model
`default_nettype wire

// >>> verification/tcp_i2c_target_tb.sv
// self-checking bench for the i2c target port
`timescale 1ns/1ps
`default_nettype none
module tcp_i2c_target_tb;
  localparam int ABN = 50;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        adr_sel = 1'b1;
  logic        win_req = 1'b0;
  logic        bus_hold = 1'b1;
  logic [6:0]  dev = 7'h44;
  logic        scl, sda, scl_low, sda_low, hang;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, rdy_o, rdy_oe_n;
  logic        mem_we, cmd_exec, wdt_rst, win_open;
  logic [7:0]  mem_addr, last_a, c;
  logic [15:0] mem_rdata = 16'h0000;
  logic [15:0] mem_wdata, last_w, w, g;
  int          err_total = 0, checked = 0, seed = 32'h0200;
  int          run = 0, run_last = 0, rl_cmd = 0, n_cmd = 0, n_wdt = 0, n0;
  always #5 clk = ~clk;
  assign scl = ~(scl_low | ~scl_oe_n | bus_hold);
  assign sda = ~(sda_low | ~sda_oe_n);
  tcp_host_model host_i (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low),
    .hang(hang));
  tcp_i2c_target #(.ABANDON_CYC(ABN), .TMO_UNIT_CYC(100), .WDT_IDLE_CYC(2000),
    .POR_WIN_CYC(200), .BUS_LOW_CYC(50)) tcp_i2c_target_i (
    .clk(clk), .rst(rst), .scl_clk(scl), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .rdy_o(rdy_o), .rdy_oe_n(rdy_oe_n),
    .adr_sel(adr_sel), .win_req(win_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .cmd_exec(cmd_exec), .wdt_rst(wdt_rst),
    .win_open(win_open));
  function automatic logic [15:0] mem_word(input logic [7:0] a);
    return {a ^ 8'h5a, a};
  endfunction : mem_word
  // ****
  // monitors and core-side memory
  // ****
  always @(posedge clk)
  begin
    run <= (scl_oe_n === 1'b0) ? run + 1 : 0;
    if (scl_oe_n === 1'b0)
      run_last <= run + 1;
    if (mem_we === 1'b1)
    begin
      last_w <= mem_wdata;
      last_a <= mem_addr;
    end
    if (cmd_exec === 1'b1)
      n_cmd <= n_cmd + 1;
    if (wdt_rst === 1'b1)
      n_wdt <= n_wdt + 1;
    mem_rdata <= mem_word(mem_addr);
  end
  // ****
  // checking
  // ****
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic cmpv(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmpv
  task automatic cmpr(input int got, input int lo, input int hi, input string m);
    checked++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("[FAIL] %0t %s %0d not in %0d..%0d", $time, m, got, lo, hi);
    end
  endtask : cmpr
  // a bound that runs out, or a host stuck on a stretch, ends the run
  task automatic lim(input int n, input int max, input string m);
    if (n >= max || hang === 1'b1)
    begin
      err_total++;
      $display("[FAIL] %0t %s timed out", $time, m);
      conclude();
    end
  endtask : lim
  task automatic wait_wdt();
    int n;
    n = 0;
    n0 = n_wdt;
    while (n_wdt == n0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    lim(n, 3000, "watchdog");
    checked++;
  endtask : wait_wdt
  // ****
  // bus transactions
  // ****
  task automatic wr_reg(input logic [7:0] cm, input logic [15:0] d, input logic ck);
    logic a0, a1, a2, a3;
    host_i.start();
    host_i.wr({dev, 1'b0}, a0);
    host_i.wr(cm, a1);
    rl_cmd = run_last;
    host_i.wr(d[7:0], a2);
    host_i.wr(d[15:8], a3);
    host_i.stop();
    lim(0, 1, "write");
    if (ck)
      cmpv(16'({a0, a1, a2, a3}), 16'h000f, "write acks");
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] cm, input logic cur, output logic [15:0] d);
    logic a0, a1;
    a1 = 1'b1;
    if (!cur)
    begin
      host_i.start();
      host_i.wr({dev, 1'b0}, a0);
      host_i.wr(cm, a1);
    end
    host_i.start();
    host_i.wr({dev, 1'b1}, a0);
    host_i.rd(1'b0, d[7:0]);
    host_i.rd(1'b1, d[15:8]);
    host_i.stop();
    lim(0, 1, "read");
    cmpv(16'({a0, a1}), 16'h0003, "read acks");
  endtask : rd_reg
  task automatic probe(input logic [6:0] a, input logic exp);
    logic ak;
    host_i.start();
    host_i.wr({a, 1'b0}, ak);
    cmpv(16'(ak), 16'(exp), "address ack");
    if (exp)
      cmpr(run_last, ABN, ABN + 10, "abandon stretch");
    host_i.stop();
  endtask : probe
  task automatic clocks(input int n);
    repeat (n) @(posedge clk);
  endtask : clocks
  // ****
  // main sequence
  // ****
  initial
  begin
    clocks(3);
    rst <= 1'b0;
    wait_wdt();
    bus_hold <= 1'b0;
    rst <= 1'b1;
    clocks(3);
    rst <= 1'b0;
    clocks(5);
    cmpv({rdy_oe_n, win_open, scl_o, sda_o, rdy_o, 3'h0, mem_addr}, 16'h8000,
      "reset outputs");
    for (int s = 0; s < 2; s++)
    begin
      adr_sel <= s[0];
      clocks(5);
      probe(7'h44, s[0]);
      probe(7'h45, ~s[0]);
    end
    adr_sel <= 1'b1;
    rd_reg(tcp_pkg::REG_TMO, 1'b0, g);
    cmpv(g, 16'(10240 / 640), "timeout default");
    rd_reg(8'h02, 1'b0, g);
    cmpv(g, mem_word(8'h02), "flags read");
    repeat (4)
    begin
      c = {1'b0, 7'($random(seed))};
      w = 16'($random(seed));
      wr_reg(c, w, 1'b1);
      cmpv(last_w, w, "write word");
      cmpv(16'(last_a), 16'(c), "write address");
      rd_reg(c, 1'b0, g);
      cmpv(g, mem_word(c), "random read");
      rd_reg(8'h00, 1'b1, g);
      cmpv(g, mem_word(c), "current read");
    end
    @(posedge clk) win_req <= 1'b1;
    @(posedge clk) win_req <= 1'b0;
    clocks(2);
    cmpv(16'({rdy_oe_n, win_open}), 16'h0001, "window line");
    wr_reg(tcp_pkg::REG_SET, 16'h0001, 1'b1);
    cmpr(rl_cmd, tcp_pkg::LOAD_CYC, tcp_pkg::LOAD_CYC + 6, "load stretch");
    clocks(4);
    cmpv(16'({rdy_oe_n, win_open}), 16'h0003, "stop ignored");
    n0 = n_cmd;
    wr_reg(tcp_pkg::REG_TMO, 16'h0002, 1'b1);
    for (int n = 0; n <= 400; n++)
    begin
      @(posedge clk);
      if (win_open === 1'b0)
      begin
        cmpr(n, 150, 215, "window timeout");
        break;
      end
      lim(n, 400, "window close");
    end
    cmpv(16'(n_cmd - n0), 16'h0000, "no command on timeout");
    rd_reg(tcp_pkg::REG_TMO, 1'b0, g);
    cmpv(g, 16'h0002, "timeout register");
    n0 = n_cmd;
    wr_reg(tcp_pkg::REG_SET, 16'h00c1, 1'b1);
    clocks(4);
    cmpv(16'({win_open, 8'(n_cmd - n0)}), 16'h0001, "end window");
    n0 = n_wdt;
    wr_reg(tcp_pkg::REG_SET, 16'h0002, 1'b0);
    clocks(4);
    cmpv(16'(n_wdt - n0), 16'h0001, "bus reset command");
    rd_reg(tcp_pkg::REG_TMO, 1'b0, g);
    cmpv(g, 16'(10240 / 640), "timeout after reinit");
    host_i.start();
    host_i.wr({dev, 1'b0}, g[0]);
    wait_wdt();
    host_i.stop();
    clocks(4);
    host_i.start();
    repeat (4)
      host_i.bitx(1'b1, g[0]);
    wait_wdt();
    host_i.stop();
    conclude();
  end
endmodule : tcp_i2c_target_tb
`default_nettype wire
